/* core/rsc_command_core.v */
// Purpose: SPI slave command interpreter of the radio, with
//          payload FIFOs and the active low radio interrupt
// Assumes: SPI mode 0; sck half period of at least 4 mclk
// Notes:   sck, chip select and mosi are synchronised here
//
// Overview of operation
// R1 - Host opens each command with chip select low
// R2 - Status byte shifts out during command byte
// R3 - Command MSB first; data LSByte first
// R4 - 000AAAAA reads register, LSByte first
// R5 - 001AAAAA writes register in power down or standby only
// R6 - 0x61 reads oldest payload, then deletes it
// R7 - 0xA0 stores new transmit payload
// R8 - 0xE1 empties transmit FIFO
// R9 - 0xE2 empties receive FIFO
// R10 - 0xE3 resends last payload until reload
// R11 - 0x60 returns width of oldest payload
// R12 - 10101PPP stores acknowledge payload, pipe 0-5
// R13 - 0xB0 stores payload sent without ack
// R14 - 0xFF does nothing, returns status
// R15 - Optional commands need optional_cmd_enable_reg bits set
// R16 - Register bytes written upward, rest kept
// R17 - Pipe field changes as interrupt falls
// R18 - Two FIFOs, three payloads of 32
// R19 - Lost links stall receive-role transmit FIFO
// R20 - Retry limit keeps current transmit payload
// R21 - FIFO status shows full and empty
// R22 - Flags drive interrupt; write one clears
// R23 - Config mask bits block each source
// R24 - Interrupt line is active low
// R25 - Host drives select and enable bits
// R26 - Chip select high ends the command
`include "rsc_regs.vh"

module rsc_command_core (
	input  wire       mclk,
	input  wire       rst,
	input  wire       chipSelectN,
	input  wire       spiSck,
	input  wire       spiMosi,
	output wire       spiMiso,
	input  wire       chipEnable,
	output reg        radioIrqN,
	output wire       primRx,
	output wire       pwrUp,
	input  wire       txStart,
	input  wire       txDone,
	input  wire       retryHit,
	input  wire [5:0] linkLost,
	output wire [7:0] txByte,
	output wire       txValid,
	input  wire       txReady,
	output wire       txLast,
	output reg        txNoAck,
	output reg        txStall,
	output wire       txEmpty,
	output wire       reuseActive,
	input  wire       rxWrValid,
	input  wire [7:0] rxWrByte,
	input  wire [2:0] rxWrPipe,
	input  wire       rxWrLast,
	output wire       rxFull
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg [7:0] txMem [0:127];     // Three slots of 32 bytes
	reg [7:0] rxMem [0:127];
	reg [7:0] regMem [0:255];    // Plain map registers, 5 bytes
	reg [5:0] txLenMem [0:2];
	reg [2:0] txPipeMem [0:2];
	reg       txNaMem [0:2];
	reg [5:0] rxLenMem [0:2];
	reg [2:0] rxPipeMem [0:2];

	reg [2:0] sckSyncFf;         // Two stages plus edge history
	reg [2:0] selSyncFf;
	reg [1:0] mosiSyncFf;
	reg [2:0] bitCntFf;
	reg [6:0] inShFf;
	reg [7:0] outShFf;
	reg       byteDoneFf;        // One pulse per whole byte
	reg [7:0] byteFf;
	reg       cmdPendFf;         // Next byte is a command
	reg [7:0] cmdFf;
	reg [5:0] dataIdxFf;         // Data bytes done so far
	reg [7:0] configFf;
	reg [7:0] featureFf;
	reg       rxFlagFf;
	reg       sentFlagFf;
	reg       retryFlagFf;
	reg [2:0] pipeFf;
	reg       reuseFf;
	reg [1:0] txHdFf;
	reg [1:0] txCntFf;
	reg [1:0] rxHdFf;
	reg [1:0] rxCntFf;
	reg [5:0] rxWrIdxFf;
	reg       rdActiveFf;
	reg [5:0] rdIdxFf;
	reg [8:0] buf0Ff;            // Last flag and byte
	reg [8:0] buf1Ff;
	reg [1:0] bufCntFf;
	reg [7:0] nxt_out;           // Byte for the next frame slot
	reg       nxt_lost;
	integer   k;                 // Reset loop index only
	integer   j;                 // Stall scan index only

	// Modulo three slot arithmetic
	function [1:0] add3;
		input [1:0] a;
		input [1:0] b;
		reg   [2:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			add3 = (s >= {1'b0, `RSC_DEPTH}) ? (s[1:0] - `RSC_DEPTH) : s[1:0];
		end
	endfunction

	// ----------------------------------------
	// Link sampling
	// ----------------------------------------
	wire sckRise  = sckSyncFf[1] & ~sckSyncFf[2];
	wire sckFall  = ~sckSyncFf[1] & sckSyncFf[2];
	wire selFall  = ~selSyncFf[1] & selSyncFf[2];
	wire selRise  = selSyncFf[1] & ~selSyncFf[2];
	wire selected = ~selSyncFf[1];

	// Synchronisers; stage 0 feeds stage 1 only
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sckSyncFf  <= 3'h0;
			selSyncFf  <= 3'h7;
			mosiSyncFf <= 2'h0;
		end else begin
			sckSyncFf  <= {sckSyncFf[1:0], spiSck};
			selSyncFf  <= {selSyncFf[1:0], chipSelectN};
			mosiSyncFf <= {mosiSyncFf[0], spiMosi};
		end
	end

	// ----------------------------------------
	// Derived state and decode
	// ----------------------------------------
	wire txFull   = (txCntFf == `RSC_DEPTH);
	wire [7:0] statusByte = {1'b0, rxFlagFf, sentFlagFf, retryFlagFf, pipeFf, txFull};
	wire [7:0] fifoByte = {1'b0, reuseFf, txFull, txEmpty, 2'h0, rxFull, rxCntFf == 2'h0};
	wire [4:0] addr     = cmdFf[4:0];
	wire isRReg   = (cmdFf[7:5] == `RSC_OP_RREG);
	wire isWReg   = (cmdFf[7:5] == `RSC_OP_WREG);
	wire isRxRd   = (cmdFf == `RSC_CMD_RXRD);
	wire isRxWid  = (cmdFf == `RSC_CMD_RXWID);
	wire isTxWr   = (cmdFf == `RSC_CMD_TXWR);
	wire isTxNa   = (cmdFf == `RSC_CMD_TXNA);
	wire isAck    = (cmdFf[7:3] == `RSC_CMD_ACK_HI);
	wire isTxLoad = isTxWr | isTxNa | isAck;
	wire cmdStart = byteDoneFf & cmdPendFf;
	wire dataByte = byteDoneFf & ~cmdPendFf;

	// R15 optional_cmd_enable_reg gating; rejected words become no-ops
	wire cmdReject = ((byteFf == `RSC_CMD_RXWID) & ~featureFf[`RSC_B_DPL])
		| ((byteFf[7:3] == `RSC_CMD_ACK_HI) & (~featureFf[`RSC_B_ACKPL]
		| (byteFf[2:0] > `RSC_PIPE_MAX)))
		| ((byteFf == `RSC_CMD_TXNA) & ~featureFf[`RSC_B_DYNACK]);

	// R5 map writes only in power down or standby
	wire wrOk   = dataByte & isWReg & ~(pwrUp & chipEnable) & (dataIdxFf < `RSC_NREGB);
	wire wrIdx0 = wrOk & (dataIdxFf == 6'h00);
	wire hostFlTx  = cmdStart & (byteFf == `RSC_CMD_FLTX);
	wire hostFlRx  = cmdStart & (byteFf == `RSC_CMD_FLRX);
	wire hostReuse = cmdStart & (byteFf == `RSC_CMD_REUSE);
	wire [1:0] txWrSlot = add3(txHdFf, txCntFf);
	wire hostTxByte = dataByte & isTxLoad & (dataIdxFf < `RSC_MAXLEN) & ~txFull;
	wire hostTxCommit = selRise & isTxLoad & (dataIdxFf != 6'h00) & ~txFull;
	wire hostRxPop = selRise & isRxRd & (dataIdxFf != 6'h00) & (rxCntFf != 2'h0);
	// R20 retry limit never pops; only a clean send does
	wire txPop = txDone & ~reuseFf & (txCntFf != 2'h0);
	wire [1:0] rxWrSlot = add3(rxHdFf, rxCntFf);
	wire rxPush = rxWrValid & rxWrLast & ~rxFull;

	assign txEmpty     = (txCntFf == 2'h0);
	assign rxFull      = (rxCntFf == `RSC_DEPTH);
	assign reuseActive = reuseFf;
	assign primRx      = configFf[`RSC_B_PRIMRX];
	assign pwrUp       = configFf[`RSC_B_PWRUP];
	assign spiMiso     = outShFf[7];

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	// R3 bits arrive and leave MSB first in every byte
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			bitCntFf   <= 3'h0;
			inShFf     <= 7'h00;
			outShFf    <= 8'h00;
			byteDoneFf <= 1'b0;
			byteFf     <= 8'h00;
		end else begin
			byteDoneFf <= 1'b0;
			if (selFall) begin
				// R2 status goes out with the command byte
				bitCntFf <= 3'h0;
				outShFf  <= statusByte;
			end else if (selected & sckRise) begin
				inShFf   <= {inShFf[5:0], mosiSyncFf[1]};
				bitCntFf <= bitCntFf + 3'h1;
				if (bitCntFf == `RSC_BIT_LAST) begin
					byteDoneFf <= 1'b1;
					byteFf     <= {inShFf, mosiSyncFf[1]};
				end
			end else if (selected & sckFall) begin
				// Whole byte done: load the next answer
				if (bitCntFf == 3'h0) begin
					outShFf <= nxt_out;
				end else begin
					outShFf <= {outShFf[6:0], 1'b0};
				end
			end
		end
	end

	// ----------------------------------------
	// Command sequencing
	// ----------------------------------------
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmdPendFf <= 1'b0;
			cmdFf     <= `RSC_CMD_NOOP;
			dataIdxFf <= 6'h00;
		end else if (selFall) begin
			// R26 fresh command after select; stale bits gone
			cmdPendFf <= 1'b1;
			cmdFf     <= `RSC_CMD_NOOP;
			dataIdxFf <= 6'h00;
		end else if (cmdStart) begin
			// R14 no-op and rejects only give the status
			cmdPendFf <= 1'b0;
			cmdFf     <= cmdReject ? `RSC_CMD_NOOP : byteFf;
			dataIdxFf <= 6'h00;
		end else if (dataByte & (dataIdxFf < `RSC_MAXLEN)) begin
			dataIdxFf <= dataIdxFf + 6'h01;
		end
	end

	// Answer byte for the next slot of the frame
	always @* begin
		nxt_out = 8'h00;
		if (isRReg) begin
			// R4 map read, byte index by data count
			case (addr)
				`RSC_A_CONFIG:  nxt_out = (dataIdxFf == 6'h00) ? configFf : 8'h00;
				`RSC_A_STATUS:  nxt_out = (dataIdxFf == 6'h00) ? statusByte : 8'h00;
				// R21 full and empty of both FIFOs
				`RSC_A_FIFOST:  nxt_out = (dataIdxFf == 6'h00) ? fifoByte : 8'h00;
				`RSC_A_OPTIONAL_CMD_ENABLE_REG: nxt_out = (dataIdxFf == 6'h00) ? featureFf : 8'h00;
				default: begin
					if (dataIdxFf < `RSC_NREGB) begin
						nxt_out = regMem[{addr, dataIdxFf[2:0]}];
					end
				end
			endcase
		end else if (isRxRd) begin
			// R6 oldest payload from byte 0 upward
			if ((rxCntFf != 2'h0) & (dataIdxFf < `RSC_MAXLEN)) begin
				nxt_out = rxMem[{rxHdFf, dataIdxFf[4:0]}];
			end
		end else if (isRxWid) begin
			// R11 width of the oldest payload
			if ((rxCntFf != 2'h0) & (dataIdxFf == 6'h00)) begin
				nxt_out = {2'h0, rxLenMem[rxHdFf]};
			end
		end
	end

	// ----------------------------------------
	// Configuration and map registers
	// ----------------------------------------
	// R23 masks clear after reset; R16 bytes from LSByte up
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			configFf  <= `RSC_RST_CONFIG;
			featureFf <= `RSC_RST_OPTIONAL_CMD_ENABLE_REG;
			for (k = 0; k < 256; k = k + 1) begin
				regMem[k] <= 8'h00;
			end
		end else if (wrOk) begin
			if (wrIdx0 & (addr == `RSC_A_CONFIG)) begin
				configFf <= byteFf;
			end else if (wrIdx0 & (addr == `RSC_A_OPTIONAL_CMD_ENABLE_REG)) begin
				featureFf <= byteFf;
			end else if ((addr != `RSC_A_STATUS) & (addr != `RSC_A_FIFOST)
				& (addr != `RSC_A_CONFIG) & (addr != `RSC_A_OPTIONAL_CMD_ENABLE_REG)) begin
				regMem[{addr, dataIdxFf[2:0]}] <= byteFf;
			end
		end
	end

	// ----------------------------------------
	// Event flags and interrupt
	// ----------------------------------------
	// R22 set beats a same-cycle write-one clear
	wire stClr = wrIdx0 & (addr == `RSC_A_STATUS);
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxFlagFf    <= 1'b0;
			sentFlagFf  <= 1'b0;
			retryFlagFf <= 1'b0;
			radioIrqN   <= 1'b1;
		end else begin
			rxFlagFf    <= rxPush | (rxFlagFf & ~(stClr & byteFf[`RSC_B_RXFLG]));
			sentFlagFf  <= txDone | (sentFlagFf & ~(stClr & byteFf[`RSC_B_SENTFLG]));
			retryFlagFf <= retryHit | (retryFlagFf & ~(stClr & byteFf[`RSC_B_RETRYFLG]));
			// R24 low while any unmasked flag stands
			radioIrqN <= ~((rxFlagFf & ~configFf[`RSC_B_RXFLG])
				| (sentFlagFf & ~configFf[`RSC_B_SENTFLG])
				| (retryFlagFf & ~configFf[`RSC_B_RETRYFLG]));
		end
	end

	// ----------------------------------------
	// Transmit FIFO control
	// ----------------------------------------
	// R18 three slots; R7 R12 R13 commit at select rise
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			txHdFf  <= 2'h0;
			txCntFf <= 2'h0;
			reuseFf <= 1'b0;
		end else if (hostFlTx) begin
			// R8 flush also ends reuse
			txCntFf <= 2'h0;
			reuseFf <= 1'b0;
		end else begin
			txCntFf <= txCntFf + {1'b0, hostTxCommit} - {1'b0, txPop};
			if (txPop) begin
				txHdFf <= add3(txHdFf, 2'h1);
			end
			// R10 reuse holds until a new 0xA0 or 0xB0 load; ack payload loads keep it
			if (hostReuse) begin
				reuseFf <= 1'b1;
			end else if (hostTxCommit & ~isAck) begin
				reuseFf <= 1'b0;
			end
		end
	end

	// Payload bytes and slot attributes
	always @(posedge mclk) begin
		if (hostTxByte) begin
			txMem[{txWrSlot, dataIdxFf[4:0]}] <= byteFf;
		end
		if (hostTxCommit) begin
			txLenMem[txWrSlot]  <= dataIdxFf;
			txPipeMem[txWrSlot] <= isAck ? cmdFf[2:0] : 3'h0;
			txNaMem[txWrSlot]   <= isTxNa;
		end
	end

	// R19 all pending pipes lost in receive role
	always @* begin
		nxt_lost = 1'b1;
		// Own index: sharing one with the reset loop gives two drivers
		for (j = 0; j < `RSC_DEPTH; j = j + 1) begin
			if (j < txCntFf) begin
				nxt_lost = nxt_lost & linkLost[txPipeMem[add3(txHdFf, j[1:0])]];
			end
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			txStall <= 1'b0;
			txNoAck <= 1'b0;
		end else begin
			txStall <= primRx & ~txEmpty & nxt_lost;
			txNoAck <= ~txEmpty & txNaMem[txHdFf];
		end
	end

	// ----------------------------------------
	// Transmit stream through two-entry buffer
	// ----------------------------------------
	wire bufPush = rdActiveFf & (bufCntFf != `RSC_BUF_FULL);
	wire bufPop  = txValid & txReady;
	wire [8:0] bufIn = {(rdIdxFf + 6'h01) >= txLenMem[txHdFf], txMem[{txHdFf, rdIdxFf[4:0]}]};
	assign txValid = (bufCntFf != 2'h0);
	assign txByte  = buf0Ff[7:0];
	assign txLast  = buf0Ff[8];

	// Reader walks the head slot; stalls when buffer full
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdActiveFf <= 1'b0;
			rdIdxFf    <= 6'h00;
		end else if (hostFlTx) begin
			rdActiveFf <= 1'b0;
		end else if (~rdActiveFf) begin
			if (txStart & ~txEmpty & ~txStall) begin
				rdActiveFf <= 1'b1;
				rdIdxFf    <= 6'h00;
			end
		end else if (bufPush) begin
			rdIdxFf <= rdIdxFf + 6'h01;
			if (bufIn[8]) begin
				rdActiveFf <= 1'b0;
			end
		end
	end

	// Buffer keeps order; a stalled receiver loses nothing
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			buf0Ff   <= 9'h000;
			buf1Ff   <= 9'h000;
			bufCntFf <= 2'h0;
		end else begin
			bufCntFf <= bufCntFf + {1'b0, bufPush} - {1'b0, bufPop};
			if (bufPop) begin
				if (bufCntFf == `RSC_BUF_FULL) begin
					buf0Ff <= buf1Ff;
				end else if (bufPush) begin
					buf0Ff <= bufIn;
				end
			end else if (bufPush) begin
				if (bufCntFf == 2'h0) begin
					buf0Ff <= bufIn;
				end else begin
					buf1Ff <= bufIn;
				end
			end
		end
	end

	// ----------------------------------------
	// Receive FIFO control
	// ----------------------------------------
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxHdFf    <= 2'h0;
			rxCntFf   <= 2'h0;
			rxWrIdxFf <= 6'h00;
			pipeFf    <= `RSC_RST_PIPE;
		end else begin
			if (rxWrValid) begin
				rxWrIdxFf <= rxWrLast ? 6'h00 :
					((rxWrIdxFf < `RSC_MAXLEN) ? rxWrIdxFf + 6'h01 : rxWrIdxFf);
			end
			if (hostFlRx) begin
				// R9 drop all received payloads
				rxCntFf <= 2'h0;
				pipeFf  <= `RSC_RST_PIPE;
			end else begin
				rxCntFf <= rxCntFf + {1'b0, rxPush} - {1'b0, hostRxPop};
				// R17 pipe moves with the flag edge
				if (hostRxPop) begin
					rxHdFf <= add3(rxHdFf, 2'h1);
					if (rxCntFf != 2'h1) begin
						pipeFf <= rxPipeMem[add3(rxHdFf, 2'h1)];
					end else begin
						pipeFf <= rxPush ? rxWrPipe : `RSC_RST_PIPE;
					end
				end else if (rxPush & (rxCntFf == 2'h0)) begin
					pipeFf <= rxWrPipe;
				end
			end
		end
	end

	// Incoming bytes land in the free slot
	always @(posedge mclk) begin
		if (rxWrValid & ~rxFull & (rxWrIdxFf < `RSC_MAXLEN)) begin
			rxMem[{rxWrSlot, rxWrIdxFf[4:0]}] <= rxWrByte;
		end
		if (rxPush) begin
			rxLenMem[rxWrSlot]  <= (rxWrIdxFf < `RSC_MAXLEN) ? rxWrIdxFf + 6'h01 : `RSC_MAXLEN;
			rxPipeMem[rxWrSlot] <= rxWrPipe;
		end
	end

endmodule // rsc_command_core

/* core/rsc_regs.vh */
// Purpose: constants of the radio SPI command core
// Assumes: included once per design file by bare name
// Notes:   patterns, map addresses, bit positions, resets
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// ----------------------------------------
// Command words
// ----------------------------------------
`define RSC_OP_RREG     3'h0
`define RSC_OP_WREG     3'h1
`define RSC_CMD_RXRD    8'h61
`define RSC_CMD_TXWR    8'hA0
`define RSC_CMD_FLTX    8'hE1
`define RSC_CMD_FLRX    8'hE2
`define RSC_CMD_REUSE   8'hE3
`define RSC_CMD_RXWID   8'h60
`define RSC_CMD_ACK_HI  5'h15
`define RSC_CMD_TXNA    8'hB0
`define RSC_CMD_NOOP    8'hFF

// ----------------------------------------
// Map addresses with live contents
// ----------------------------------------
`define RSC_A_CONFIG    5'h00
`define RSC_A_STATUS    5'h07
`define RSC_A_FIFOST    5'h17
`define RSC_A_OPTIONAL_CMD_ENABLE_REG   5'h1D

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define RSC_B_RXFLG     6
`define RSC_B_SENTFLG   5
`define RSC_B_RETRYFLG  4
`define RSC_B_PWRUP     1
`define RSC_B_PRIMRX    0
`define RSC_B_DPL       2
`define RSC_B_ACKPL     1
`define RSC_B_DYNACK    0

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define RSC_RST_CONFIG  8'h08
`define RSC_RST_OPTIONAL_CMD_ENABLE_REG 8'h00
`define RSC_RST_PIPE    3'h7
`define RSC_DEPTH       2'h3
`define RSC_MAXLEN      6'h20
`define RSC_NREGB       6'h05
`define RSC_PIPE_MAX    3'h5
`define RSC_BIT_LAST    3'h7
`define RSC_BUF_FULL    2'h2

`endif

/* test/rsc_command_core_props.sv */
// Purpose: port-level checks on the radio SPI command core
// Assumes: one clock domain, rst asynchronous and active high
// Notes:   bound to every instance of the core
module rsc_command_core_props (
	input wire       mclk,
	input wire       rst,
	input wire       chipSelectN,
	input wire       spiMiso,
	input wire       radioIrqN,
	input wire       primRx,
	input wire       txStart,
	input wire       txDone,
	input wire       retryHit,
	input wire       rxWrValid,
	input wire       rxWrLast,
	input wire [7:0] txByte,
	input wire       txValid,
	input wire       txReady,
	input wire       txLast,
	input wire       txStall,
	input wire       txEmpty,
	input wire       reuseActive,
	input wire       rxFull
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Clocking and helper
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire setEv = txDone || retryHit || (rxWrValid && rxWrLast); // Any flag source
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Idle levels on the first edge out of reset
	property p_rstval;
		$fell(rst) |-> radioIrqN && txEmpty && !rxFull && !reuseActive && !txValid;
	endproperty
	a_rstval: assert property (p_rstval) else $error("outputs off reset level");
	// Line only falls two or three edges after a flag source
	property p_irqfall;
		$fell(radioIrqN) |-> $past(setEv, 2) || $past(setEv, 3);
	endproperty
	a_irqfall: assert property (p_irqfall) else $error("irq fell without source");
	// Release only comes from a host write inside a frame
	property p_irqrise;
		$rose(radioIrqN) |-> !chipSelectN;
	endproperty
	a_irqrise: assert property (p_irqrise) else $error("irq rose outside frame");
	// Status bit 7 is zero and leads every frame
	property p_status;
		$fell(chipSelectN) |-> ##4 !spiMiso;
	endproperty
	a_status: assert property (p_status) else $error("status msb not first");
	// Stream only starts two edges after a start pulse
	property p_vstart;
		$rose(txValid) |-> $past(txStart, 2);
	endproperty
	a_vstart: assert property (p_vstart) else $error("txValid without start");
	// A refused byte stands unchanged
	property p_hold;
		txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast);
	endproperty
	a_hold: assert property (p_hold) else $error("tx byte moved while stalled");
	// Reuse changes only through commands
	property p_reusechg;
		$changed(reuseActive) |-> !$past(chipSelectN, 6);
	endproperty
	a_reusechg: assert property (p_reusechg) else $error("reuse changed off frame");
	// Reuse keeps the payload after it is sent
	property p_reusekeep;
		reuseActive && txDone && !txEmpty |=> !txEmpty;
	endproperty
	a_reusekeep: assert property (p_reusekeep) else $error("reused payload popped");
	// Retry limit keeps the payload
	property p_retry;
		retryHit && !txEmpty |=> !txEmpty;
	endproperty
	a_retry: assert property (p_retry) else $error("payload lost on retry limit");
	// Stall only in receive role with something queued
	property p_stall;
		$rose(txStall) |-> $past(primRx) && !$past(txEmpty);
	endproperty
	a_stall: assert property (p_stall) else $error("stall without cause");
endmodule // rsc_command_core_props

bind rsc_command_core rsc_command_core_props u_props (
	.mclk, .rst, .chipSelectN, .spiMiso, .radioIrqN, .primRx, .txStart, .txDone,
	.retryHit, .rxWrValid, .rxWrLast, .txByte, .txValid, .txReady, .txLast,
	.txStall, .txEmpty, .reuseActive, .rxFull
);

/* test/rsc_command_core_test.sv */
// Purpose: self-checking bench of the radio SPI command core
// Assumes: host model runs the SPI at 80 ns a bit
// Notes:   radio-side pins driven here on the rising edge
module rsc_command_core_test;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       mclk = 1'b0;       // 125 MHz clock
	logic       rst = 1'b1;        // Async reset
	logic       chipEnable = 1'b0; // Radio enable
	logic [2:0] ev = 3'h0;         // Retry, done, start pulses
	logic [5:0] linkLost = 6'h00;  // Per-pipe link lost
	logic       txReady = 1'b0;    // Radio takes a byte
	logic       rxWrValid = 1'b0;  // Rx byte strobe
	logic [7:0] rxWrByte = 8'h00;  // Rx byte
	logic [2:0] rxWrPipe = 3'h0;   // Rx pipe
	logic       rxWrLast = 1'b0;   // Rx packet end
	wire        txStart = ev[0];
	wire        txDone = ev[1];
	wire        retryHit = ev[2];
	wire        chipSelectN, spiSck, spiMosi, spiMiso, radioIrqN, primRx, pwrUp;
	wire        txValid, txLast, txNoAck, txStall, txEmpty, reuseActive, rxFull;
	wire  [7:0] txByte;
	logic [7:0] wq[$];             // Data bytes to send
	logic [7:0] rq[$];             // Reply, status first
	int         n_fail = 0;
	int         n_checks = 0;
	int         cyc = 0;           // Hang guard
	rsc_command_core dut (
		.mclk, .rst, .chipSelectN, .spiSck, .spiMosi, .spiMiso, .chipEnable,
		.radioIrqN, .primRx, .pwrUp, .txStart, .txDone, .retryHit, .linkLost,
		.txByte, .txValid, .txReady, .txLast, .txNoAck, .txStall, .txEmpty,
		.reuseActive, .rxWrValid, .rxWrByte, .rxWrPipe, .rxWrLast, .rxFull
	);
	rsc_host_model host (.mclk, .chipSelectN, .spiSck, .spiMosi, .spiMiso);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	always #4 mclk = ~mclk;
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Missing data bytes go out as zero
	task automatic cmd(input logic [7:0] op, input int n);
		logic [7:0] tq[$];
		tq = {op};
		for (int i = 0; i < n; i++)
			tq.push_back(i < wq.size() ? wq[i] : 8'h00);
		host.xfer(tq, rq);
		wq = {};
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		wq = {d};
		cmd({3'h1, a}, 1);
	endtask
	// Long tail so a flag has reached the line
	task automatic pulse(input logic [2:0] m);
		ev <= m;
		wt(1);
		ev <= 3'h0;
		wt(4);
	endtask
	task automatic rxpkt(input int n, input logic [2:0] p);
		for (int i = 0; i < n; i++) begin
			rxWrValid <= 1'b1;
			rxWrByte <= {p, i[4:0]};
			rxWrPipe <= p;
			rxWrLast <= (i == n - 1);
			wt(1);
		end
		rxWrValid <= 1'b0;
		rxWrLast <= 1'b0;
		wt(3);
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_basic;
		chk({3'h0, txEmpty, radioIrqN, rxFull, reuseActive, txValid}, 8'h18);
		cmd(8'hFF, 0);
		chk(rq[0], 8'h0E);
	endtask
	// Write refused when powered and enabled; bytes kept above a short write
	task automatic t_regs;
		logic [7:0] e[5] = '{8'hAA, 8'h22, 8'h33, 8'h44, 8'h55};
		wr(5'h00, 8'h03);
		chk({6'h00, pwrUp, primRx}, 8'h03);
		chipEnable <= 1'b1;
		wr(5'h00, 8'h00);
		cmd(8'h00, 1);
		chk(rq[1], 8'h03);
		chipEnable <= 1'b0;
		wr(5'h00, 8'h00);
		wq = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		cmd(8'h2A, 5);
		wr(5'h0A, 8'hAA);
		cmd(8'h0A, 5);
		for (int i = 0; i < 5; i++)
			chk(rq[i + 1], e[i]);
	endtask
	// Stalled stream, sent flag, clear, then masked source
	task automatic t_tx;
		int k = 0;
		wq = {8'h10, 8'h21, 8'h32};
		cmd(8'hA0, 3);
		cmd(8'h17, 1);
		chk(rq[1], 8'h01);
		txReady <= 1'b0;
		pulse(3'h1);
		txReady <= 1'b1;
		for (int g = 0; g < 40 && k < 3; g++) begin
			wt(1);
			if (txValid && txReady) begin
				chk(txByte, 8'h10 + 8'h11 * k[7:0]);
				chk({7'h00, txLast}, {7'h00, k == 2});
				k++;
			end
		end
		chk(k[7:0], 8'h03);
		txReady <= 1'b0;
		pulse(3'h2);
		chk({6'h00, txEmpty, radioIrqN}, 8'h02);
		cmd(8'hFF, 0);
		chk(rq[0], 8'h2E);
		wr(5'h07, 8'h20);
		chk({7'h00, radioIrqN}, 8'h01);
		wr(5'h00, 8'h20);
		cmd(8'hA0, 1);
		pulse(3'h2);
		chk({7'h00, radioIrqN}, 8'h01);
		wr(5'h07, 8'h20);
		wr(5'h00, 8'h00);
	endtask
	task automatic t_reuse;
		cmd(8'hA0, 1);
		cmd(8'hE3, 0);
		chk({7'h00, reuseActive}, 8'h01);
		pulse(3'h2);
		chk({7'h00, txEmpty}, 8'h00);
		wr(5'h07, 8'h20);
		cmd(8'hA0, 1);
		chk({7'h00, reuseActive}, 8'h00);
		cmd(8'hE3, 0);
		cmd(8'hE1, 0);
		chk({6'h00, txEmpty, reuseActive}, 8'h02);
		cmd(8'hA0, 1);
		pulse(3'h4);
		chk({6'h00, txEmpty, radioIrqN}, 8'h00);
		cmd(8'hFF, 0);
		chk(rq[0], 8'h1E);
		wr(5'h07, 8'h10);
		cmd(8'hE1, 0);
	endtask
	// Width, read with delete, fill to refusal, flush
	task automatic t_rx;
		rxpkt(4, 3'h2);
		cmd(8'hFF, 0);
		chk({radioIrqN, rq[0][6:0]}, 8'h44);
		wr(5'h1D, 8'h07);
		cmd(8'h60, 1);
		chk(rq[1], 8'h04);
		cmd(8'h61, 4);
		for (int i = 0; i < 4; i++)
			chk(rq[i + 1], {3'h2, i[4:0]});
		cmd(8'h17, 1);
		chk(rq[1], 8'h11);
		wr(5'h07, 8'h40);
		for (int i = 0; i < 4; i++)
			rxpkt(1, 3'h1);
		chk({7'h00, rxFull}, 8'h01);
		cmd(8'hE2, 0);
		cmd(8'h17, 1);
		chk(rq[1], 8'h11);
		wr(5'h07, 8'h40);
	endtask
	// Every pipe, a bad pipe, a lost link, no-ack load
	task automatic t_ack;
		wr(5'h00, 8'h01);
		for (int p = 0; p < 6; p++) begin
			cmd(8'hA8 | p[7:0], 1);
			chk({7'h00, txEmpty}, 8'h00);
			cmd(8'hE1, 0);
		end
		cmd(8'hAE, 1);
		chk({7'h00, txEmpty}, 8'h01);
		linkLost <= 6'h04;
		cmd(8'hAA, 1);
		wt(2);
		chk({6'h00, txStall, txEmpty}, 8'h02);
		cmd(8'hE1, 0);
		chk({6'h00, txStall, txEmpty}, 8'h01);
		linkLost <= 6'h00;
		wr(5'h00, 8'h00);
		wr(5'h1D, 8'h00);
		cmd(8'hB0, 1);
		chk({7'h00, txEmpty}, 8'h01);
		wr(5'h1D, 8'h01);
		cmd(8'hB0, 1);
		wt(2);
		chk({6'h00, txNoAck, txEmpty}, 8'h02);
		cmd(8'hE1, 0);
	endtask
	// ----------------------------------------
	// Sequence and hang guard
	// ----------------------------------------
	initial begin
		wt(8);
		rst <= 1'b0;
		wt(5);
		t_basic();
		t_regs();
		t_tx();
		t_reuse();
		t_rx();
		t_ack();
		print_verdict();
	end
	// Whole run is near 9500 clocks
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			print_verdict();
		end
	end
endmodule // rsc_command_core_test

/* test/rsc_host_model.sv */
// Purpose: host SPI master in front of the core's command port
// Assumes: mode 0, sck parked low, 80 ns bit time
// Notes:   sck stands still between frames, mosi is not held
module rsc_host_model (
	input  wire  mclk,
	output logic chipSelectN,
	output logic spiSck,
	output logic spiMosi,
	input  wire  spiMiso
);
	timeunit 1ns;
	timeprecision 1ps;
	// Deselected with clock parked at time zero
	initial begin
		chipSelectN = 1'b1;
		spiSck = 1'b0;
		spiMosi = 1'b0;
	end
	// Whole system clocks; half a bit is five
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One frame: command then data, reply gathered per byte
	task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
		logic [7:0] r;
		rx = {};
		chipSelectN <= 1'b0;
		foreach (tx[i]) begin
			for (int b = 7; b >= 0; b--) begin
				spiMosi <= tx[i][b];
				wt(5);
				spiSck <= 1'b1;
				r[b] = spiMiso;
				wt(5);
				spiSck <= 1'b0;
			end
			rx.push_back(r);
		end
		wt(5);
		chipSelectN <= 1'b1;
		spiMosi <= ~spiMosi;
		wt(6);
	endtask
endmodule // rsc_host_model
